// ==== dp_diag_telegram.sv ====
/*
 Diagnostic telegram builder: Avalon-MM register slave, fault class
 collection and a byte stream that carries the telegram to the master side.
 Assumes fault inputs come from logic on clk_sys_i and that the consumer
 of the byte stream honours valid/ready.
*/
`timescale 1ns/1ps
module dp_diag_telegram
    import dp_diag_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [31:0] fault_class_i,
    input  wire logic        alarm_active_i,
    output tg_byte_t         tg_byte_o,
    output logic             tg_valid_o,
    input  wire logic        tg_ready_i,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic        ack_r;
    logic [31:0] rdata_r;
    logic        lib_mode_r;
    logic [15:0] station_r;
    logic [5:0]  module_num_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic        wr_fire;
    logic        start_req;
    logic        busy;
    logic        group_diag;
    logic        overflow_r;
    logic [8:0]  length_r;
    logic [8:0]  length_nxt;
    logic [31:0] faults;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
    assign avs_readdata_o    = rdata_r;
    assign wr_fire           = avs_write_i & ack_r;
    assign start_req         = wr_fire && (avs_address_i == REG_CTRL) && avs_writedata_i[CTRL_START];

    // One wait state: read data is latched before the accepting edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_r <= 32'h0000_0000;
        else if (avs_read_i && !ack_r)
        begin
            if (avs_address_i == REG_CTRL)
                rdata_r <= {30'h0000_0000, lib_mode_r, 1'b0};
            else if (avs_address_i == REG_STATION)
                rdata_r <= {16'h0000, station_r};
            else if (avs_address_i == REG_MODULE)
                rdata_r <= {26'h000_0000, module_num_r};
            else if (avs_address_i == REG_STATUS)
                rdata_r <= {20'h0_0000, length_r, overflow_r, group_diag, busy};
            else if (avs_address_i == REG_IRQ_STAT)
                rdata_r <= {29'h0000_0000, irq_stat_r};
            else if (avs_address_i == REG_IRQ_EN)
                rdata_r <= {29'h0000_0000, irq_en_r};
            else
                rdata_r <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lib_mode_r   <= 1'b0;
            station_r    <= 16'h0000;
            module_num_r <= 6'h00;
            irq_en_r     <= '0;
        end
        else if (wr_fire)
        begin
            if (avs_address_i == REG_CTRL)
                lib_mode_r <= avs_writedata_i[CTRL_LIB];
            else if (avs_address_i == REG_STATION)
                station_r <= avs_writedata_i[15:0];
            else if (avs_address_i == REG_MODULE)
                module_num_r <= avs_writedata_i[5:0];
            else if (avs_address_i == REG_IRQ_EN)
                irq_en_r <= avs_writedata_i[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault collection

    // Unknown class numbers are dropped; one bit per class merges duplicates
    assign faults     = fault_class_i & CLASS_VALID;                      // [R9] [R10] [R11]
    assign group_diag = (|faults) | alarm_active_i;

    function automatic logic [5:0] count_ones(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++)
            n = n + {5'h00, v[i]};
        return n;
    endfunction

    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] k;
        k = 5'h00;
        for (int i = 31; i >= 0; i--)
            if (v[i])
                k = 5'(i);
        return k;
    endfunction

    // Mode comes from the start write itself: the mode register updates on that same edge
    always_comb
    begin
        length_nxt = {6'h00, STN_BYTES} + {3'h0, IDENT_LEN}
                   + {3'h0, (avs_writedata_i[CTRL_LIB] ? MOD_LEN_LIB : MOD_LEN_GSD)}
                   + 9'(count_ones(faults) * CHN_BYTES);
    end

    ////////////////////////////////////////////////////////////////////////
    // Telegram sequencer

    tg_state_t   state_r;
    logic [2:0]  idx_r;
    logic [31:0] pend_r;
    logic        snap_diag_r;
    logic        snap_lib_r;
    logic [4:0]  cur_cls;
    logic        gen_fire;
    logic        last_byte;
    tg_byte_t    gen_byte;
    logic [7:0]  slot_byte;
    logic [5:0]  mod_len;

    assign busy      = (state_r != ST_IDLE) | tg_valid_o;
    assign gen_fire  = (state_r != ST_IDLE) & (~tg_valid_o | tg_ready_i);
    assign cur_cls   = lowest_set(pend_r);
    assign mod_len   = snap_lib_r ? MOD_LEN_LIB : MOD_LEN_GSD;

    always_comb
    begin
        slot_byte = 8'h00;
        slot_byte[snap_lib_r ? SLOT_BIT_LIB : SLOT_BIT_GSD] = snap_diag_r; // [R3] [R5]
    end

    always_comb
    begin
        gen_byte      = '0;
        last_byte     = 1'b0;
        gen_byte.sop  = (state_r == ST_STN) && (idx_r == 3'h0);               // [R13]
        case (state_r)
            ST_STN:
            begin
                case (idx_r)
                    3'h0:
                    begin
                        gen_byte.data[SS1_PRM_FAULT] = station_r[STN_PRM_FAULT];
                        gen_byte.data[SS1_EXT_DIAG]  = snap_diag_r;             // [R1]
                        gen_byte.data[SS1_CFG_FAULT] = station_r[STN_CFG_FAULT];
                        gen_byte.data[SS1_NOT_READY] = station_r[STN_NOT_READY];
                    end
                    3'h1:
                    begin
                        gen_byte.data[SS2_SYNC]    = station_r[STN_SYNC];
                        gen_byte.data[SS2_FREEZE]  = station_r[STN_FREEZE];
                        gen_byte.data[SS2_WD_ON]   = station_r[STN_WD_ON];
                        gen_byte.data[SS2_PRM_REQ] = station_r[STN_PRM_REQ];
                    end
                    3'h2:    gen_byte.data[SS3_OVERFLOW] = overflow_r;         // [R2]
                    3'h3:    gen_byte.data = station_r[STN_ADDR_LSB +: 8];
                    3'h4:    gen_byte.data = IDENT_NUMBER[15:8];
                    default: gen_byte.data = IDENT_NUMBER[7:0];
                endcase
            end
            ST_IDB:
                gen_byte.data = (idx_r == 3'h0) ? {HDR_IDENT, IDENT_LEN} : slot_byte; // [R4]
            ST_MOD:
            begin
                if (idx_r == 3'h0)
                    gen_byte.data = {HDR_MODULE, mod_len};
                else if (idx_r == 3'h1)
                    gen_byte.data = MOD_STATUS;
                else
                    gen_byte.data = {4{SLOT_VALID}};                           // [R6]
                last_byte = (idx_r == 3'(mod_len - 6'h01)) && (pend_r == 32'h0000_0000);
            end
            ST_CHN:
            begin
                if (idx_r == 3'h0)
                    gen_byte.data = {HDR_CHANNEL, module_num_r};               // [R12]
                else if (idx_r == 3'h1)
                    gen_byte.data = {CH_IO, 6'h00};                            // [R7]
                else
                    gen_byte.data = {CH_UNSPEC, 1'b0, cur_cls};                // [R8]
                last_byte = (idx_r == CHN_BYTES - 3'h1) && ((pend_r & (pend_r - 32'h1)) == 32'h0);
            end
            default: gen_byte.data = 8'h00;
        endcase
        gen_byte.eop = last_byte;
    end

    // Blocks follow in fixed order after the station block
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r     <= ST_IDLE;
            idx_r       <= 3'h0;
            pend_r      <= 32'h0000_0000;
            snap_diag_r <= 1'b0;
            snap_lib_r  <= 1'b0;
            overflow_r  <= 1'b0;
            length_r    <= 9'h000;
        end
        else if (state_r == ST_IDLE)
        begin
            if (start_req && !tg_valid_o)
            begin
                // Fault state is frozen so one telegram is self-consistent
                state_r     <= ST_STN;
                idx_r       <= 3'h0;
                pend_r      <= faults;
                snap_diag_r <= group_diag;
                snap_lib_r  <= avs_writedata_i[CTRL_LIB];
                length_r    <= length_nxt;
                overflow_r  <= length_nxt > DIAG_MAX;                          // [R2]
            end
        end
        else if (gen_fire)
        begin
            idx_r <= idx_r + 3'h1;
            case (state_r)
                ST_STN:
                    if (idx_r == STN_BYTES - 3'h1)
                    begin
                        state_r <= ST_IDB;                                     // [R14]
                        idx_r   <= 3'h0;
                    end
                ST_IDB:
                    if (idx_r == 3'(IDENT_LEN - 6'h01))
                    begin
                        state_r <= ST_MOD;
                        idx_r   <= 3'h0;
                    end
                ST_MOD:
                    if (idx_r == 3'(mod_len - 6'h01))
                    begin
                        state_r <= last_byte ? ST_IDLE : ST_CHN;
                        idx_r   <= 3'h0;
                    end
                ST_CHN:
                    if (idx_r == CHN_BYTES - 3'h1)
                    begin
                        pend_r  <= pend_r & (pend_r - 32'h1);                  // [R11]
                        state_r <= last_byte ? ST_IDLE : ST_CHN;
                        idx_r   <= 3'h0;
                    end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tg_byte_o  <= '0;
            tg_valid_o <= 1'b0;
        end
        else if (gen_fire)
        begin
            tg_byte_o  <= gen_byte;
            tg_valid_o <= 1'b1;
        end
        else if (tg_ready_i)
            tg_valid_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    logic             diag_d_r;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    always_comb
    begin
        irq_set           = '0;
        irq_set[IRQ_DONE] = tg_valid_o & tg_ready_i & tg_byte_o.eop;
        irq_set[IRQ_DIAG] = group_diag & ~diag_d_r;
        irq_set[IRQ_OVF]  = (state_r == ST_IDLE) && start_req && !tg_valid_o && (length_nxt > DIAG_MAX);
        irq_clr           = (wr_fire && (avs_address_i == REG_IRQ_CLR)) ? avs_writedata_i[IRQ_W-1:0] : '0;
    end

    // Set beats clear in the same cycle so no event is lost
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            diag_d_r   <= 1'b0;
            irq_stat_r <= '0;
        end
        else
        begin
            diag_d_r   <= group_diag;
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign irq_o = |(irq_stat_r & irq_en_r);

endmodule

// ==== dp_diag_pkg.sv ====
/*
 Constants, register map, field positions and carrier types for the
 diagnostic telegram builder. Assumes one 10 MHz system clock.
*/
// Contract
// [R1] Group diagnostic flag follows any active fault
// [R2] Overflow flag set above 240 report bytes
// [R3] Slot bit set while slot diagnostic active
// [R4] Identifier header coded 01, length two
// [R5] Slot bit 0 description file, 3 library
// [R6] Every module slot status reads 00
// [R7] Channel byte two coded 11, rest zero
// [R8] Channel byte three type 00, class low
// [R9] Classes 22 to 26 drive faults
// [R10] Classes 2,3,9,16-21,27-30 other faults
// [R11] One channel entry per active class
// [R12] Channel header 10 plus module number
// [R13] Six-byte station status block first
// [R14] Identifier, module, channel blocks follow
// [R15] Master must run in DPV1 mode
package dp_diag_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATION  = 8'h04;
    localparam logic [7:0] REG_MODULE   = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_EN   = 8'h14;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h18;
    // Control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_LIB   = 1;
    // Station register fields
    localparam int STN_PRM_REQ   = 0;
    localparam int STN_NOT_READY = 1;
    localparam int STN_CFG_FAULT = 2;
    localparam int STN_WD_ON     = 3;
    localparam int STN_FREEZE    = 4;
    localparam int STN_SYNC      = 5;
    localparam int STN_PRM_FAULT = 6;
    localparam int STN_ADDR_LSB  = 8;
    // Telegram bit positions
    localparam int SS1_PRM_FAULT = 6;
    localparam int SS1_EXT_DIAG  = 3;
    localparam int SS1_CFG_FAULT = 2;
    localparam int SS1_NOT_READY = 1;
    localparam int SS2_SYNC      = 5;
    localparam int SS2_FREEZE    = 4;
    localparam int SS2_WD_ON     = 3;
    localparam int SS2_PRM_REQ   = 0;
    localparam int SS3_OVERFLOW  = 7;
    localparam int SLOT_BIT_GSD  = 0;
    localparam int SLOT_BIT_LIB  = 3;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DIAG = 1;
    localparam int IRQ_OVF  = 2;
    localparam int IRQ_W    = 3;
    // Block codes and lengths
    localparam logic [1:0] HDR_IDENT   = 2'b01;
    localparam logic [1:0] HDR_MODULE  = 2'b00;
    localparam logic [1:0] HDR_CHANNEL = 2'b10;
    localparam logic [5:0] IDENT_LEN   = 6'h02;
    localparam logic [5:0] MOD_LEN_GSD = 6'h05;
    localparam logic [5:0] MOD_LEN_LIB = 6'h06;
    localparam logic [7:0] MOD_STATUS  = 8'h82;
    localparam logic [1:0] SLOT_VALID  = 2'b00;
    localparam logic [1:0] CH_IO       = 2'b11;
    localparam logic [1:0] CH_UNSPEC   = 2'b00;
    localparam logic [2:0] STN_BYTES   = 3'h6;
    localparam logic [2:0] CHN_BYTES   = 3'h3;
    localparam logic [8:0] DIAG_MAX    = 9'h0f0;
    // Message classes 2,3,9,16..30
    localparam logic [31:0] CLASS_VALID = 32'h7fff_020c;
    // Arbitrary neutral identity value
    localparam logic [15:0] IDENT_NUMBER = 16'h1234;

    typedef enum logic [2:0] {ST_IDLE, ST_STN, ST_IDB, ST_MOD, ST_CHN} tg_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       sop;
        logic       eop;
    } tg_byte_t;
endpackage

// ==== dp_diag_telegram_checker.sv ====
/*
 Checker for the diagnostic telegram builder: stream framing and bus timing.
 Sees only the builder's ports; bound from the testbench top.
*/
`timescale 1ns/1ps
module dp_diag_telegram_checker
    import dp_diag_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [31:0] fault_class_i,
    input wire logic        alarm_active_i,
    input wire tg_byte_t    tg_byte_o,
    input wire logic        tg_valid_o,
    input wire logic        tg_ready_i,
    input wire logic        irq_o
);
    logic       acc;
    logic       mid;
    logic [7:0] idx_r;
    logic [7:0] d1_r;
    logic [7:0] cls_r;
    logic       g_r;
    assign acc = tg_valid_o && tg_ready_i;
    assign mid = acc && !tg_byte_o.sop;
    ////////////////////////////////////////////////////////////////////////////
    // Byte index within the telegram, last byte and last class seen
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            idx_r <= 8'h00;
            d1_r  <= 8'h00;
            cls_r <= 8'h00;
            g_r   <= 1'b0;
        end
        else if (acc)
        begin
            idx_r <= tg_byte_o.sop ? 8'h01 : idx_r + 8'h01;
            d1_r  <= tg_byte_o.data;
            cls_r <= tg_byte_o.sop ? 8'h00 : ((idx_r >= 8'h0f && d1_r == 8'hc0) ? tg_byte_o.data : cls_r);
            g_r   <= tg_byte_o.sop ? tg_byte_o.data[SS1_EXT_DIAG] : g_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_hold; tg_valid_o && !tg_ready_i |=> tg_valid_o && $stable(tg_byte_o); endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    property p_ss1;
        tg_valid_o && tg_byte_o.sop |-> tg_byte_o.data[7] == 1'b0 && tg_byte_o.data[5] == 1'b0 && tg_byte_o.data[0]
            == 1'b0 && tg_byte_o.data[SS1_EXT_DIAG] == (alarm_active_i || (fault_class_i & CLASS_VALID) != 32'h0);
    endproperty
    a_ss1: assert property (p_ss1) else $error("station status one wrong");
    property p_ss3; mid && idx_r == 8'h02 |-> tg_byte_o.data == 8'h00; endproperty
    a_ss3: assert property (p_ss3) else $error("station status three wrong");
    property p_ident; mid && idx_r == 8'h06 |-> tg_byte_o.data == 8'h42; endproperty
    a_ident: assert property (p_ident) else $error("identifier header wrong");
    property p_slot;
        mid && idx_r == 8'h07 |-> tg_byte_o.data == {4'h0, g_r, 3'h0} || tg_byte_o.data == {7'h0, g_r};
    endproperty
    a_slot: assert property (p_slot) else $error("slot bit byte wrong");
    property p_mod_hdr; mid && idx_r == 8'h08 |-> tg_byte_o.data inside {8'h05, 8'h06}; endproperty
    a_mod_hdr: assert property (p_mod_hdr) else $error("module header wrong");
    property p_mod_body;
        mid && idx_r inside {[8'h09:8'h0c]} |-> tg_byte_o.data == ((idx_r == 8'h09) ? 8'h82 : 8'h00);
    endproperty
    a_mod_body: assert property (p_mod_body) else $error("module status wrong");
    property p_ch_io; mid && idx_r >= 8'h0e && d1_r[7:6] == 2'b10 |-> tg_byte_o.data == 8'hc0; endproperty
    a_ch_io: assert property (p_ch_io) else $error("channel io byte wrong");
    property p_ch_cls;
        mid && idx_r >= 8'h0f && d1_r == 8'hc0 |-> tg_byte_o.data[7:5] == 3'h0
            && CLASS_VALID[tg_byte_o.data[4:0]] && tg_byte_o.data > cls_r;
    endproperty
    a_ch_cls: assert property (p_ch_cls) else $error("channel class byte wrong");
    property p_eop; acc && tg_byte_o.eop |=> !tg_valid_o; endproperty
    a_eop: assert property (p_eop) else $error("valid after last byte");
    property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("more than one wait state");
    property p_unmapped; avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h14 |-> avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_stall: cover property (tg_valid_o && !tg_ready_i);
    c_class: cover property (mid && idx_r >= 8'h0f && d1_r == 8'hc0);
    c_lib: cover property (mid && idx_r == 8'h07 && tg_byte_o.data == 8'h08);
endmodule

// ==== dp_master_model.sv ====
/*
 Master side of the telegram stream: collects accepted bytes in a queue.
 Assumes the testbench selects stalling and reads the queue.
*/
`timescale 1ns/1ps
module dp_master_model
    import dp_diag_pkg::*;
(
    input  wire logic     clk_sys_i,
    input  wire logic     rst_n_i,
    input  wire tg_byte_t tg_byte_i,
    input  wire logic     tg_valid_i,
    input  wire logic     stall_i,
    output logic          tg_ready_o
);
    tg_byte_t got[$];
    // Stalling toggles ready so each byte after the first must hold across a refused edge
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tg_ready_o <= 1'b0;
        else
            tg_ready_o <= stall_i ? ~tg_ready_o : 1'b1;
    end
    always @(posedge clk_sys_i)
    begin
        if (rst_n_i && tg_valid_i && tg_ready_o)
            got.push_back(tg_byte_i);
    end
endmodule

// ==== dp_diag_telegram_tb.sv ====
/*
 Self-checking bench for the diagnostic telegram builder.
 Assumes the master model and checker files are compiled before it.
*/
`timescale 1ns/1ps
module dp_diag_telegram_tb
    import dp_diag_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [31:0] fault_class_i = 32'h0;
    logic        alarm_active_i = 1'b0;
    tg_byte_t    tg_byte_o;
    logic        tg_valid_o;
    logic        tg_ready_i;
    logic        irq_o;
    logic        stall = 1'b0;
    logic [31:0] q;
    int          num_errors = 0;
    int          checks_done = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    dp_diag_telegram dp_diag_telegram_inst (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .fault_class_i, .alarm_active_i, .tg_byte_o,
        .tg_valid_o, .tg_ready_i, .irq_o);
    dp_master_model dp_master_model_inst (.clk_sys_i, .rst_n_i, .tg_byte_i(tg_byte_o), .tg_valid_i(tg_valid_o),
        .stall_i(stall), .tg_ready_o(tg_ready_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon transfer; waitrequest is sampled at the edge, before it updates
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0)
        begin
            check("bus timeout", 32'h1, 32'h0);
            summarize();
        end
    endtask
    function automatic logic cls_ok(int k);
        return k == 2 || k == 3 || k == 9 || (k >= 16 && k <= 30);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic run_tg(input logic lib, input logic [31:0] f, input logic al, input logic [15:0] st,
                          input logic [5:0] mn, input logic stl, input logic twice);
        logic [7:0] exp[$];
        logic       g;
        int         n;
        logic [31:0] s;
        logic [31:0] e;
        g = al;
        for (int k = 0; k < 32; k++)
            g = g | (f[k] & cls_ok(k));
        @(posedge clk_sys_i);
        fault_class_i <= f;
        alarm_active_i <= al;
        stall <= stl;
        bus(1'b1, REG_STATION, {16'h0, st});
        bus(1'b1, REG_MODULE, {26'h0, mn});
        dp_master_model_inst.got.delete();
        exp.push_back({1'b0, st[6], 2'b00, g, st[2], st[1], 1'b0});
        exp.push_back({2'b00, st[5], st[4], st[3], 2'b00, st[0]});
        exp.push_back(8'h00);
        exp.push_back(st[15:8]);
        exp.push_back(IDENT_NUMBER[15:8]);
        exp.push_back(IDENT_NUMBER[7:0]);
        exp.push_back(8'h42);
        exp.push_back(g ? (lib ? 8'h08 : 8'h01) : 8'h00);
        exp.push_back(lib ? 8'h06 : 8'h05);
        exp.push_back(8'h82);
        for (int k = 0; k < (lib ? 4 : 3); k++)
            exp.push_back(8'h00);
        for (int k = 0; k < 32; k++)
            if (f[k] && cls_ok(k))
            begin
                exp.push_back({2'b10, mn});
                exp.push_back(8'hc0);
                exp.push_back(8'(k));
            end
        bus(1'b1, REG_CTRL, {30'h0, lib, 1'b1});
        if (twice)
            bus(1'b1, REG_CTRL, {30'h0, lib, 1'b1});
        n = 0;
        do
        begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        while (q[0] !== 1'b0 && n < 100);
        if (q[0] !== 1'b0)
        begin
            check("busy timeout", 32'h1, 32'h0);
            summarize();
        end
        check("status", q, {20'h0, 9'(exp.size()), 1'b0, g, 1'b0});
        check("byte count", dp_master_model_inst.got.size(), exp.size());
        foreach (exp[i])
        begin
            s = {22'h0, dp_master_model_inst.got[i]};
            e = {22'h0, exp[i], i == 0, i == exp.size() - 1};
            check("telegram byte", s, e);
        end
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        check("done flag", {31'h0, q[IRQ_DONE]}, 32'h1);
    endtask
    task automatic sc_reset_values();
        logic [7:0] adr[8] = '{REG_CTRL, REG_STATION, REG_MODULE, REG_STATUS,
                               REG_IRQ_STAT, REG_IRQ_EN, REG_IRQ_CLR, 8'h40};
        foreach (adr[i])
        begin
            bus(1'b0, adr[i], 32'h0);
            check("reset read", q, 32'h0);
        end
        check("irq at reset", {31'h0, irq_o}, 32'h0);
    endtask
    task automatic sc_irq();
        bus(1'b1, REG_IRQ_CLR, 32'h7);
        bus(1'b1, REG_IRQ_EN, 32'h1);
        @(negedge clk_sys_i);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        run_tg(1'b1, 32'h0040_0004, 1'b0, 16'h125f, 6'h01, 1'b0, 1'b0);
        @(negedge clk_sys_i);
        check("irq raised", {31'h0, irq_o}, 32'h1);
        bus(1'b1, REG_IRQ_EN, 32'h0);
        @(negedge clk_sys_i);
        check("irq masked", {31'h0, irq_o}, 32'h0);
        bus(1'b1, REG_IRQ_EN, 32'h1);
        bus(1'b1, REG_IRQ_CLR, 32'h7);
        @(negedge clk_sys_i);
        check("irq after clear", {31'h0, irq_o}, 32'h0);
        // Group diagnostics falls, then rises again through the alarm input alone
        @(posedge clk_sys_i);
        fault_class_i <= 32'h0;
        @(posedge clk_sys_i);
        alarm_active_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        check("diag rise", q, 32'h2);
        check("irq diag masked", {31'h0, irq_o}, 32'h0);
        bus(1'b0, REG_IRQ_EN, 32'h0);
        check("irq enable", q, 32'h1);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        sc_reset_values();
        run_tg(1'b0, 32'h0, 1'b0, 16'ha55f, 6'h00, 1'b0, 1'b0);
        run_tg(1'b1, 32'h0, 1'b1, 16'h0320, 6'h3f, 1'b1, 1'b0);
        run_tg(1'b0, 32'hffff_ffff, 1'b0, 16'h7f5f, 6'h2a, 1'b1, 1'b1);
        sc_irq();
        summarize();
    end
endmodule
bind dp_diag_telegram dp_diag_telegram_checker dp_diag_telegram_checker_inst (.clk_sys_i, .rst_n_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .fault_class_i,
    .alarm_active_i, .tg_byte_o, .tg_valid_o, .tg_ready_i, .irq_o);
